// file: dmasf_top.sv
/*
  status flags of a two-channel dma controller behind an avalon-mm slave
  with waitrequest: raw done, raw fault, active channels, masked fault,
  and a sticky interrupt status with mask and one level interrupt.
  assumes all inputs are synchronous to clock_in and that the transfer
  engine pulses count_zero_in when a channel's remaining count hits zero.
*/
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
// Summary of operation
// R01 - raw done flag per channel, bits 0-1
// R02 - raw fault flag per channel, bits 0-1
// R03 - active flag per channel, bits 0-1
// R04 - active flag clears when count reaches zero
// R05 - raw done flags reset to zero
// R06 - writing one to done clear clears flag
// R07 - masked fault shows fault after enable masking
// R08 - upper bits read zero, no read side effects
`include "dmasf_defines.svh"

module dmasf_top (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [5:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  input  wire logic [1:0]  done_event_in,
  input  wire logic [1:0]  fault_event_in,
  input  wire logic [1:0]  count_zero_in,
  output logic      [1:0]  chan_active_out,
  output logic             irq_out
);
  dmasf_pkg::dmasf_bus_state_t state;
  dmasf_pkg::dmasf_bus_state_t next_state;
  dmasf_pkg::dmasf_chan_vec_t  raw_done_flag;
  dmasf_pkg::dmasf_chan_vec_t  raw_fault_flag;
  dmasf_pkg::dmasf_chan_vec_t  chan_active_flag;
  dmasf_pkg::dmasf_chan_vec_t  masked_fault_flag;
  dmasf_pkg::dmasf_chan_vec_t  fault_enable;
  dmasf_pkg::dmasf_irq_vec_t   irq_status;
  dmasf_pkg::dmasf_irq_vec_t   irq_mask;
  dmasf_pkg::dmasf_irq_vec_t   irq_events;
  dmasf_pkg::dmasf_irq_vec_t   next_irq_status;
  dmasf_pkg::dmasf_word_t      read_mux;
  logic                        request;
  logic                        accept;
  logic                        wr_take;
  logic                        lane0;
  dmasf_pkg::dmasf_chan_vec_t  done_clear_stb;
  dmasf_pkg::dmasf_chan_vec_t  fault_clear_stb;
  logic                        enable_write;
  logic                        hit_raw_done;
  logic                        hit_raw_fault;
  logic                        hit_active;
  logic                        hit_mask_fault;
  logic                        hit_irq_status;
  logic                        hit_irq_mask;
  logic                        hit_done_clear;
  logic                        hit_fault_clear;
  logic                        hit_chan_enable;
  logic                        hit_fault_en;

  // word decode; the two low address bits are ignored
  function automatic logic dmasf_hit(input logic [5:0] addr, input logic [5:0] off);
    dmasf_hit = (addr[5:2] == off[5:2]);
  endfunction : dmasf_hit

  // widen a two-bit channel field to a bus word, upper bits zero
  function automatic dmasf_pkg::dmasf_word_t dmasf_word2(input logic [1:0] v);
    dmasf_word2 = {30'h0, v};
  endfunction : dmasf_word2

  // address decode
  assign hit_raw_done    = dmasf_hit(address_in, `DMASF_OFF_RAW_DONE);
  assign hit_raw_fault   = dmasf_hit(address_in, `DMASF_OFF_RAW_FAULT);
  assign hit_active      = dmasf_hit(address_in, `DMASF_OFF_ACTIVE);
  assign hit_mask_fault  = dmasf_hit(address_in, `DMASF_OFF_MASK_FAULT);
  assign hit_irq_status  = dmasf_hit(address_in, `DMASF_OFF_IRQ_STATUS);
  assign hit_irq_mask    = dmasf_hit(address_in, `DMASF_OFF_IRQ_MASK);
  assign hit_done_clear  = dmasf_hit(address_in, `DMASF_OFF_DONE_CLEAR);
  assign hit_fault_clear = dmasf_hit(address_in, `DMASF_OFF_FAULT_CLEAR);
  assign hit_chan_enable = dmasf_hit(address_in, `DMASF_OFF_CHAN_ENABLE);
  assign hit_fault_en    = dmasf_hit(address_in, `DMASF_OFF_FAULT_EN);

  // one wait state per access; the answer edge is the only write edge
  assign request         = read_in | write_in;
  assign accept          = (state == dmasf_pkg::DMASF_ACK) & clk_en_in;
  assign waitrequest_out = request & ~accept;
  assign wr_take         = write_in & accept;
  assign lane0           = byteenable_in[0];

  // write strobes; all live fields sit in byte lane 0
  assign done_clear_stb  = (wr_take & lane0 & hit_done_clear) ?
                           writedata_in[`DMASF_CH_MSB:`DMASF_CH_LSB] : 2'h0; // R06
  assign fault_clear_stb = (wr_take & lane0 & hit_fault_clear) ?
                           writedata_in[`DMASF_CH_MSB:`DMASF_CH_LSB] : 2'h0;
  assign enable_write    = wr_take & lane0 & hit_chan_enable;

  // per-channel flag logic
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      dmasf_chan u_chan (
        .clock_in        (clock_in),
        .reset_n_in      (reset_n_in),
        .clk_en_in       (clk_en_in),
        .done_event_in   (done_event_in[ch]),
        .fault_event_in  (fault_event_in[ch]),
        .count_zero_in   (count_zero_in[ch]),
        .done_clear_in   (done_clear_stb[ch]),
        .fault_clear_in  (fault_clear_stb[ch]),
        .enable_write_in (enable_write),
        .enable_value_in (writedata_in[ch]),
        .raw_done_out    (raw_done_flag[ch]),
        .raw_fault_out   (raw_fault_flag[ch]),
        .active_out      (chan_active_flag[ch])
      );
    end
  endgenerate

  // the fault is gated by its enable only on the masked view
  assign masked_fault_flag = raw_fault_flag & fault_enable; // R07
  assign chan_active_out   = chan_active_flag;              // R03

  // sticky interrupt status: an event beats a write-one-to-clear
  assign irq_events      = {fault_event_in, done_event_in};
  assign next_irq_status = irq_events |
                           (irq_status & ~((wr_take & lane0 & hit_irq_status) ?
                                           writedata_in[3:0] : 4'h0));
  assign irq_out         = |(irq_status & irq_mask);

  // read selection; unmapped words read zero and reads change nothing
  assign read_mux =
    hit_raw_done   ? dmasf_word2(raw_done_flag)     : // R01
    hit_raw_fault  ? dmasf_word2(raw_fault_flag)    : // R02
    hit_active     ? dmasf_word2(chan_active_flag)  : // R03
    hit_mask_fault ? dmasf_word2(masked_fault_flag) : // R07
    hit_irq_status ? {28'h000_0000, irq_status}     :
    hit_irq_mask   ? {28'h000_0000, irq_mask}       :
    hit_fault_en   ? dmasf_word2(fault_enable)      :
                     `DMASF_RST_WORD;                 // R08

  // bus state walks idle -> ack -> idle; a stalled ack is held by the enable
  always_comb begin
    next_state = dmasf_pkg::DMASF_IDLE;
    unique case (state)
      dmasf_pkg::DMASF_IDLE: next_state = request ? dmasf_pkg::DMASF_ACK : dmasf_pkg::DMASF_IDLE;
      dmasf_pkg::DMASF_ACK:  next_state = dmasf_pkg::DMASF_IDLE;
    endcase
  end

  // bus state and read data; data is caught in the wait cycle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state        <= dmasf_pkg::DMASF_IDLE;
      readdata_out <= `DMASF_RST_WORD;
    end else if (clk_en_in) begin
      state <= next_state;
      if (read_in && state == dmasf_pkg::DMASF_IDLE) begin
        readdata_out <= read_mux;
      end
    end
  end

  // software-written control and the sticky status
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status   <= `DMASF_RST_IRQ;
      irq_mask     <= `DMASF_RST_IRQ;
      fault_enable <= `DMASF_RST_FLAGS;
    end else if (clk_en_in) begin
      irq_status <= next_irq_status;
      if (wr_take && lane0 && hit_irq_mask) begin
        irq_mask <= writedata_in[3:0];
      end
      if (wr_take && lane0 && hit_fault_en) begin
        fault_enable <= writedata_in[`DMASF_CH_MSB:`DMASF_CH_LSB];
      end
    end
  end

  // bus handshake steps
  sequence s_fresh_req;
    request && state == dmasf_pkg::DMASF_IDLE && clk_en_in;
  endsequence
  sequence s_answer;
    !waitrequest_out && state == dmasf_pkg::DMASF_ACK;
  endsequence

  one_wait_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    s_fresh_req ##0 waitrequest_out |=> (!clk_en_in) or s_answer)
    else $error("slave did not answer after one wait state");
  // a low clock enable must freeze the sticky status and the bus state
  freeze_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !clk_en_in |=> $stable(irq_status) && $stable(state))
    else $error("state moved while the clock enable was low");
  clear_ch1_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R06
    wr_take && lane0 && hit_done_clear && writedata_in[1] && !done_event_in[1] |=> !raw_done_flag[1])
    else $error("bus write of one did not clear channel 1 done flag");
  act_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R03
    chan_active_flag[1] && !count_zero_in[1] && !enable_write |=> chan_active_flag[1])
    else $error("channel 1 active flag dropped without cause");
  rd_done_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R01
    s_fresh_req ##0 (read_in && hit_raw_done) |=> readdata_out == dmasf_word2($past(raw_done_flag)))
    else $error("raw done word read wrong");
  rd_masked_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R07
    s_fresh_req ##0 (read_in && hit_mask_fault) |=>
      readdata_out[1:0] == ($past(raw_fault_flag) & $past(fault_enable)))
    else $error("masked fault word read wrong");
  upper_zero_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R08
    s_answer ##0 read_in |-> readdata_out[31:4] == 28'h000_0000)
    else $error("upper read bits not zero");
  en_set_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R03
    enable_write && writedata_in[0] && !count_zero_in[0] |=> chan_active_flag[0])
    else $error("channel 0 not active after enable write");
  irq_raise_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    clk_en_in && done_event_in[0] && irq_mask[0] && !(wr_take && hit_irq_mask) |=> irq_out)
    else $error("unmasked done event raised no interrupt");
  rst_done_a: assert property (@(posedge clock_in) // R05
    $rose(reset_n_in) |-> raw_done_flag == 2'h0)
    else $error("raw done flags not zero after reset");
endmodule : dmasf_top

// file: dmasf_defines.svh
/*
  constants of the dma status-flag block: register byte offsets,
  field positions, reset values and the bus wait figure.
  assumes it is included by bare name after the package.
*/
`ifndef DMASF_DEFINES_SVH
`define DMASF_DEFINES_SVH

// byte offsets on the register bus
`define DMASF_OFF_RAW_DONE    6'h00
`define DMASF_OFF_RAW_FAULT   6'h04
`define DMASF_OFF_ACTIVE      6'h08
`define DMASF_OFF_MASK_FAULT  6'h0c
`define DMASF_OFF_IRQ_STATUS  6'h10
`define DMASF_OFF_IRQ_MASK    6'h14
`define DMASF_OFF_DONE_CLEAR  6'h18
`define DMASF_OFF_FAULT_CLEAR 6'h1c
`define DMASF_OFF_CHAN_ENABLE 6'h20
`define DMASF_OFF_FAULT_EN    6'h24

// field positions
`define DMASF_CH_LSB          0
`define DMASF_CH_MSB          1
`define DMASF_IRQ_DONE_LSB    0
`define DMASF_IRQ_FAULT_LSB   2

// reset values
`define DMASF_RST_FLAGS       2'h0
`define DMASF_RST_IRQ         4'h0
`define DMASF_RST_WORD        32'h0000_0000

// cycles from request to waitrequest low
`define DMASF_WAIT_CYCLES     1

`endif

// file: dmasf_pkg.sv
/*
  types of the dma status-flag block.
  assumes nothing of its surroundings.
*/
package dmasf_pkg;
  typedef enum logic [0:0] {
    DMASF_IDLE = 1'b0,
    DMASF_ACK  = 1'b1
  } dmasf_bus_state_t;

  typedef logic [1:0]  dmasf_chan_vec_t;
  typedef logic [3:0]  dmasf_irq_vec_t;
  typedef logic [31:0] dmasf_word_t;
endpackage : dmasf_pkg

// file: dmasf_chan.sv
/*
  one channel's flags: raw done, raw fault and the active state.
  assumes events and the count-zero pulse are synchronous to clock_in
  and that clears arrive as one-cycle strobes from the register bus.
*/
module dmasf_chan (
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  input  wire logic done_event_in,
  input  wire logic fault_event_in,
  input  wire logic count_zero_in,
  input  wire logic done_clear_in,
  input  wire logic fault_clear_in,
  input  wire logic enable_write_in,
  input  wire logic enable_value_in,
  output logic      raw_done_out,
  output logic      raw_fault_out,
  output logic      active_out
);
  logic next_raw_done;
  logic next_raw_fault;
  logic next_active;

  // a new event beats a clear in the same cycle, so no completion is lost
  assign next_raw_done  = done_event_in | (raw_done_out & ~done_clear_in);   // R01
  assign next_raw_fault = fault_event_in | (raw_fault_out & ~fault_clear_in); // R02
  // completion beats a fresh enable: a held count of zero cannot restart
  assign next_active    = count_zero_in ? 1'b0 :                              // R04
                          (enable_write_in ? enable_value_in : active_out);   // R03

  // flags start cleared
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      raw_done_out  <= 1'b0; // R05
      raw_fault_out <= 1'b0;
      active_out    <= 1'b0;
    end else if (clk_en_in) begin
      raw_done_out  <= next_raw_done;
      raw_fault_out <= next_raw_fault;
      active_out    <= next_active;
    end
  end

  done_set_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R01
    clk_en_in && done_event_in |=> raw_done_out)
    else $error("raw done flag missed its event");
  done_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R06
    clk_en_in && done_clear_in && !done_event_in |=> !raw_done_out)
    else $error("raw done flag survived a clear");
  fault_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R02
    raw_fault_out && !fault_clear_in |=> raw_fault_out)
    else $error("raw fault flag dropped without a clear");
  active_drop_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R04
    clk_en_in && count_zero_in |=> !active_out)
    else $error("active flag stayed set after count reached zero");
endmodule : dmasf_chan

// file: dmasf_top_tb.sv
/*
  self-checking bench of the dma status-flag block: avalon-mm read and
  write tasks, event pulses, and sequences of calls with expected values.
  assumes the design files and dmasf_defines.svh are compiled before it.
*/
`include "dmasf_defines.svh"

module dmasf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock_in;
  logic        reset_n_in;
  logic        clk_en_in;
  logic [5:0]  address_in;
  logic        read_in;
  logic        write_in;
  logic [31:0] writedata_in;
  logic [3:0]  byteenable_in;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic [1:0]  done_event_in;
  logic [1:0]  fault_event_in;
  logic [1:0]  count_zero_in;
  logic [1:0]  chan_active_out;
  logic        irq_out;
  int          num_errors;
  int          cmp_count;

  dmasf_top u_dut (
    .clock_in        (clock_in),
    .reset_n_in      (reset_n_in),
    .clk_en_in       (clk_en_in),
    .address_in      (address_in),
    .read_in         (read_in),
    .write_in        (write_in),
    .writedata_in    (writedata_in),
    .byteenable_in   (byteenable_in),
    .readdata_out    (readdata_out),
    .waitrequest_out (waitrequest_out),
    .done_event_in   (done_event_in),
    .fault_event_in  (fault_event_in),
    .count_zero_in   (count_zero_in),
    .chan_active_out (chan_active_out),
    .irq_out         (irq_out)
  );

  // 25 mhz clock
  always #20 clock_in = ~clock_in;

  task automatic final_report();
    $display("checks %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus_access(input logic wr, input logic [5:0] addr, input logic [31:0] wdata,
                            input logic [3:0] be, output logic [31:0] rdata);
    int n;
    rdata = 32'h0000_0000;
    @(posedge clock_in);
    address_in    <= addr;
    read_in       <= ~wr;
    write_in      <= wr;
    writedata_in  <= wdata;
    byteenable_in <= be;
    // sample at the rising edge itself, before that edge's updates land
    for (n = 0; n < 20; n++) begin
      @(posedge clock_in);
      if (waitrequest_out === 1'b0) begin
        rdata = readdata_out;
        break;
      end
    end
    read_in  <= 1'b0;
    write_in <= 1'b0;
    if (n == 20) begin
      num_errors++;
      $display("wrong value waitrequest_out expected 0 seen 1");
      final_report();
    end
  endtask : bus_access

  task automatic wr_reg(input logic [5:0] addr, input logic [31:0] data, input logic [3:0] be);
    logic [31:0] unused;
    bus_access(1'b1, addr, data, be, unused);
  endtask : wr_reg

  task automatic rd_chk(input logic [5:0] addr, input logic [31:0] exp, input string name);
    logic [31:0] got;
    bus_access(1'b0, addr, 32'h0000_0000, 4'hf, got);
    check_word(name, exp, got);
  endtask : rd_chk

  // one-cycle event pulses from the transfer engine
  task automatic pulse(input logic [1:0] d, input logic [1:0] f, input logic [1:0] z);
    @(posedge clock_in);
    done_event_in  <= d;
    fault_event_in <= f;
    count_zero_in  <= z;
    @(posedge clock_in);
    done_event_in  <= 2'h0;
    fault_event_in <= 2'h0;
    count_zero_in  <= 2'h0;
  endtask : pulse

  // main sequence
  initial begin
    clock_in = 1'b0; reset_n_in = 1'b0; clk_en_in = 1'b1; address_in = 6'h00;
    read_in = 1'b0; write_in = 1'b0; writedata_in = 32'h0000_0000; byteenable_in = 4'hf;
    done_event_in = 2'h0; fault_event_in = 2'h0; count_zero_in = 2'h0;
    num_errors = 0; cmp_count = 0;
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd_chk(`DMASF_OFF_RAW_DONE, 32'h0000_0000, "raw done");
    rd_chk(`DMASF_OFF_RAW_FAULT, 32'h0000_0000, "raw fault");
    rd_chk(`DMASF_OFF_ACTIVE, 32'h0000_0000, "active");
    check_bit("irq_out", 1'b0, irq_out);
    // both channels finish; a write to the read-only word must not stick
    pulse(2'h3, 2'h0, 2'h0);
    rd_chk(`DMASF_OFF_RAW_DONE, 32'h0000_0003, "raw done");
    rd_chk(`DMASF_OFF_RAW_DONE, 32'h0000_0003, "raw done reread");
    wr_reg(`DMASF_OFF_RAW_DONE, 32'hffff_ffff, 4'hf);
    rd_chk(`DMASF_OFF_RAW_DONE, 32'h0000_0003, "raw done read only");
    wr_reg(`DMASF_OFF_DONE_CLEAR, 32'h0000_0000, 4'hf);
    rd_chk(`DMASF_OFF_RAW_DONE, 32'h0000_0003, "raw done zero clear");
    wr_reg(`DMASF_OFF_DONE_CLEAR, 32'h0000_0002, 4'hf);
    rd_chk(`DMASF_OFF_RAW_DONE, 32'h0000_0001, "raw done cleared");
    // an event while the clock enable is low must be ignored
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    pulse(2'h2, 2'h0, 2'h0);
    @(posedge clock_in);
    clk_en_in <= 1'b1;
    rd_chk(`DMASF_OFF_RAW_DONE, 32'h0000_0001, "raw done frozen");
    // interrupt raised, masked, unmasked and cleared
    rd_chk(`DMASF_OFF_IRQ_STATUS, 32'h0000_0003, "irq status");
    check_bit("irq_out masked", 1'b0, irq_out);
    wr_reg(`DMASF_OFF_IRQ_MASK, 32'h0000_0001, 4'hf);
    @(negedge clock_in);
    check_bit("irq_out unmasked", 1'b1, irq_out);
    wr_reg(`DMASF_OFF_IRQ_STATUS, 32'h0000_0001, 4'hf);
    rd_chk(`DMASF_OFF_IRQ_STATUS, 32'h0000_0002, "irq status cleared");
    check_bit("irq_out cleared", 1'b0, irq_out);
    pulse(2'h1, 2'h0, 2'h0);
    @(negedge clock_in);
    check_bit("irq_out new event", 1'b1, irq_out);
    wr_reg(`DMASF_OFF_IRQ_STATUS, 32'h0000_0001, 4'hf);
    rd_chk(`DMASF_OFF_IRQ_STATUS, 32'h0000_0002, "irq status recleared");
    // channel 1 error, raw and after enable gating
    pulse(2'h0, 2'h2, 2'h0);
    rd_chk(`DMASF_OFF_RAW_FAULT, 32'h0000_0002, "raw fault");
    rd_chk(`DMASF_OFF_MASK_FAULT, 32'h0000_0000, "masked fault off");
    wr_reg(`DMASF_OFF_FAULT_EN, 32'h0000_0003, 4'hf);
    rd_chk(`DMASF_OFF_MASK_FAULT, 32'h0000_0002, "masked fault on");
    wr_reg(`DMASF_OFF_FAULT_CLEAR, 32'h0000_0002, 4'hf);
    rd_chk(`DMASF_OFF_RAW_FAULT, 32'h0000_0000, "raw fault cleared");
    // enable without lane 0 is ignored, then a real enable and a count end
    wr_reg(`DMASF_OFF_CHAN_ENABLE, 32'h0000_0003, 4'h0);
    rd_chk(`DMASF_OFF_ACTIVE, 32'h0000_0000, "active no lane");
    wr_reg(`DMASF_OFF_CHAN_ENABLE, 32'h0000_0003, 4'hf);
    rd_chk(`DMASF_OFF_ACTIVE, 32'h0000_0003, "active");
    check_word("chan_active_out", 32'h0000_0003, {30'h0, chan_active_out});
    pulse(2'h0, 2'h0, 2'h1);
    rd_chk(`DMASF_OFF_ACTIVE, 32'h0000_0002, "active after count end");
    check_bit("chan_active_out ch0", 1'b0, chan_active_out[0]);
    // a second reset in mid-run clears the set flags again
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd_chk(`DMASF_OFF_RAW_DONE, 32'h0000_0000, "raw done after reset");
    rd_chk(`DMASF_OFF_ACTIVE, 32'h0000_0000, "active after reset");
    rd_chk(6'h3c, 32'h0000_0000, "unmapped");
    final_report();
  end
endmodule : dmasf_top_tb
